//--- hdl/sit_pkg.sv
// shared constants, enumerations and state carriers of the interrupt timer
// assumes a 100 MHz bus clock and AHB-Lite register access
package sit_pkg;
	localparam int CLK_NS        = 10;
	localparam int TSTATE_NS     = 500;
	localparam int STATE_CYC     = (TSTATE_NS + CLK_NS - 1) / CLK_NS;
	localparam int STATES_PER_MC = 5;
	localparam int TMR_PRESCALE  = 32;
	localparam logic [5:0] DIV_LAST = 6'(STATE_CYC - 1);
	localparam logic [2:0] IDX_LAST = 3'(STATES_PER_MC - 1);
	localparam logic [4:0] PRE_LAST = 5'(TMR_PRESCALE - 1);

	localparam logic [11:0] EXT_VECTOR = 12'h003;
	localparam logic [11:0] TMR_VECTOR = 12'h007;
	localparam logic [7:0]  COUNT_MAX  = 8'hFF;
	localparam logic [11:0] RST_PC     = 12'h000;
	localparam logic [2:0]  RST_SP     = 3'h0;
	localparam logic [7:0]  RST_BYTE   = 8'h00;

	localparam logic [7:0] ADDR_CMD   = 8'h00;
	localparam logic [7:0] ADDR_ACC   = 8'h04;
	localparam logic [7:0] ADDR_STAT  = 8'h08;
	localparam logic [7:0] ADDR_CORE  = 8'h0C;
	localparam logic [7:0] ADDR_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_COUNT = 8'h14;
	localparam logic [7:0] ADDR_DBB   = 8'h18;

	localparam int ST_IBF = 0;
	localparam int ST_TOVF = 1;
	localparam int ST_EXTP = 2;
	localparam int ST_TMRP = 3;
	localparam int ST_INSV = 4;
	localparam int ST_EXTE = 5;
	localparam int ST_TMRE = 6;
	localparam int ST_BUSY = 7;
	localparam int ST_HOLD = 8;
	localparam int ST_JTF = 9;
	localparam int ST_PIN = 10;
	localparam int ST_MODE = 11;
	localparam int CORE_SP = 12;
	localparam int FLG_BANK = 4;
	localparam int FLG_F0 = 5;
	localparam int FLG_F1 = 6;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_EN_EXT = 4'h1, OP_DIS_EXT = 4'h2,
		OP_EN_TMR = 4'h3, OP_DIS_TMR = 4'h4, OP_START_COUNT = 4'h5,
		OP_START_TIMER = 4'h6, OP_STOP = 4'h7, OP_LOAD_COUNTER = 4'h8,
		OP_READ_COUNTER = 4'h9, OP_JUMP_TF = 4'hA, OP_RETURN = 4'hB,
		OP_IN_DBB = 4'hC, OP_OUT_PORTS = 4'hD
	} sit_op_e;
	typedef enum logic [2:0] {
		FSM_IDLE = 3'b001, FSM_CYC1 = 3'b010, FSM_CYC2 = 3'b100
	} sit_fsm_e;
	typedef enum logic [2:0] {
		MODE_STOP = 3'b001, MODE_TIMER = 3'b010, MODE_EVENT = 3'b100
	} sit_mode_e;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} sit_ahb_s;
	typedef struct packed {
		logic [5:0] div;
		logic [2:0] idx;
		logic [4:0] pre;
	} sit_cyc_s;
	typedef struct packed {
		sit_ahb_s        ahb;
		logic [31:0]     hrdata;
		sit_fsm_e        fsm;
		sit_op_e         op;
		sit_op_e         cmd_op;
		logic            cmd_pend;
		logic [7:0]      acc;
		logic [7:0]      count;
		sit_mode_e       mode;
		logic            tovf;
		logic            input_buffer_full_flag;
		logic [7:0]      dbb;
		logic            ext_pend;
		logic            tmr_pend;
		logic            in_service;
		logic            ext_en;
		logic            tmr_en;
		logic [11:0]     pc;
		logic [2:0]      sp;
		logic            bank;
		logic            f0;
		logic            f1;
		logic            jtf_taken;
		logic            ports_input;
		logic            wr_seen;
		logic [7:0][15:0] stack;
	} sit_state_s;

	function automatic logic op_two_cycle(sit_op_e op);
		return (op == OP_JUMP_TF) || (op == OP_RETURN);
	endfunction
endpackage

//--- hdl/sit_cycle.sv
// state clock and machine cycle generator with the timer prescaler
// assumes hclk at 100 MHz; mcyc_end and tmr_tick are one-clock enables, sync_out spans a whole state
`timescale 1ns/10ps
module sit_cycle import sit_pkg::*; (
	input  wire logic hclk,      // bus clock
	input  wire logic hresetn,   // async reset, active low
	output logic      mcyc_end,  // last clock of a machine cycle
	output logic      tmr_tick,  // every 32nd machine cycle end
	output logic      sync_out   // high in the first state of a cycle
);
	sit_cyc_s st, nx;
	logic     state_tick;

	assign state_tick = (st.div == DIV_LAST);
	assign mcyc_end   = state_tick && (st.idx == IDX_LAST);
	assign tmr_tick   = mcyc_end && (st.pre == PRE_LAST);
	assign sync_out   = (st.idx == 3'h0);

	always_comb begin
		nx = st;
		nx.div = state_tick ? 6'h00 : st.div + 6'h01;
		if (state_tick) begin
			nx.idx = (st.idx == IDX_LAST) ? 3'h0 : st.idx + 3'h1;
		end
		if (mcyc_end) begin
			nx.pre = st.pre + 5'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	mc_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
		mcyc_end |-> ##250 mcyc_end)
		else $error("machine cycle is not five states long");
endmodule

//--- hdl/sit_edge.sv
// falling edge detector for the event input
// assumes the pin is already synchronous to hclk
`timescale 1ns/10ps
module sit_edge (
	input  wire logic hclk,     // bus clock
	input  wire logic hresetn,  // async reset, active low
	input  wire logic pin,      // event input level
	output logic      fall      // one clock pulse per falling edge
);
	logic prev, next_prev;

	// idle high, so a pin held low through reset counts one edge on the first clock after it
	assign next_prev = pin;
	assign fall      = prev && !pin;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev <= 1'b1;
		end else begin
			prev <= next_prev;
		end
	end
endmodule

//--- hdl/sit_top.sv
// interrupt, timer/event counter, cycle and single-step control of a
// slave controller core, with its instruction stream fed over AHB-Lite
// assumes synchronous pins and a single master on the register bus
//
// Behaviour
// - master select plus write raises external request
// - sample per cycle, call address 3 afterwards
// - interrupt pushes PC and status like calls
// - one level; next taken in return's cycle two
// - external wins over simultaneous timer request
// - enabled timer request calls address 7
// - disabled timer overflow only sets the flag
// - disabled external request stays pending
// - 8-bit counter loaded and read via accumulator
// - reset stops counter but keeps its count
// - FF wraps to 00, flag and request
// - jump on flag clears flag; reset too
// - held timer request waits for the return
// - event mode counts event pin falling edges
// - timer mode counts machine cycles divided 32
// - five states per cycle, one/two cycle instructions
// - reset clears core state and disables interrupts
// - step input low halts between instructions
// - master write sets, buffer input clears flag
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
module sit_top import sit_pkg::*; (
	input  wire logic        hclk,           // bus clock, 100 MHz
	input  wire logic        hresetn,        // async reset, active low
	input  wire logic        hsel,           // slave select
	input  wire logic [31:0] haddr,          // byte address
	input  wire logic [1:0]  htrans,         // transfer type
	input  wire logic        hwrite,         // write when high
	input  wire logic [2:0]  hsize,          // word only
	input  wire logic [31:0] hwdata,         // write data
	input  wire logic        hready,         // bus ready
	output logic             hreadyout,      // always ready
	output logic [31:0]      hrdata,         // registered read data
	output logic             hresp,          // always OKAY
	input  wire logic        cs_n,           // master chip select
	input  wire logic        wr_n,           // master write strobe
	input  wire logic        a0,             // master data/command select
	input  wire logic [7:0]  din,            // master data bus
	input  wire logic        event_input_pin, // event counter input
	input  wire logic        single_step_n,  // low holds the core
	output logic             sync_out,       // cycle sync
	output logic             port_input_mode // ports in input mode
);
	sit_state_s st, nx;
	logic ev_fall, mcyc_end, tmr_tick;
	logic ahb_take, dph_wr, ext_irq, tmr_irq, irq_accept;
	logic cnt_inc, cnt_ovf, mw_event, finish, boundary, call;
	logic [11:0] ret_pc, push_pc;
	logic [2:0]  push_sp;

	sit_cycle sit_cycle_i (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.mcyc_end (mcyc_end),
		.tmr_tick (tmr_tick),
		.sync_out (sync_out)
	);

	sit_edge sit_edge_i (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin     (event_input_pin),
		.fall    (ev_fall)
	);

	function automatic logic [31:0] reg_read(logic [7:0] a, sit_state_s s);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			ADDR_ACC: r[7:0] = s.acc;
			ADDR_STAT: begin
				r[ST_IBF]  = s.input_buffer_full_flag;
				r[ST_TOVF] = s.tovf;
				r[ST_EXTP] = s.ext_pend;
				r[ST_TMRP] = s.tmr_pend;
				r[ST_INSV] = s.in_service;
				r[ST_EXTE] = s.ext_en;
				r[ST_TMRE] = s.tmr_en;
				r[ST_BUSY] = s.cmd_pend;
				r[ST_HOLD] = !single_step_n;
				r[ST_JTF]  = s.jtf_taken;
				r[ST_PIN]  = s.ports_input;
				r[ST_MODE +: 3] = s.mode;
			end
			ADDR_CORE: begin
				r[11:0] = s.pc;
				r[CORE_SP +: 3] = s.sp;
			end
			ADDR_FLAGS: begin
				r[FLG_BANK] = s.bank;
				r[FLG_F0]   = s.f0;
				r[FLG_F1]   = s.f1;
			end
			ADDR_COUNT: r[7:0] = s.count;
			ADDR_DBB: r[7:0] = s.dbb;
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	assign hreadyout       = 1'b1;
	assign hresp           = 1'b0;
	assign hrdata          = st.hrdata;
	assign port_input_mode = st.ports_input;

	assign ahb_take = hsel && htrans[1] && hready;
	assign dph_wr   = st.ahb.valid && st.ahb.write;
	// a held strobe is one request, taken on its first low cycle
	assign mw_event = !cs_n && !wr_n && !st.wr_seen;
	assign ext_irq  = st.ext_pend && st.ext_en;
	assign tmr_irq  = st.tmr_pend && st.tmr_en;
	assign irq_accept = (ext_irq || tmr_irq) && !st.in_service;
	assign cnt_inc  = ((st.mode == MODE_TIMER) && tmr_tick)
		|| ((st.mode == MODE_EVENT) && ev_fall);
	assign cnt_ovf  = cnt_inc && (st.count == COUNT_MAX);
	assign finish   = mcyc_end && (((st.fsm == FSM_CYC1)
		&& !op_two_cycle(st.op)) || (st.fsm == FSM_CYC2));
	assign boundary = mcyc_end && ((st.fsm == FSM_IDLE) || finish);
	assign call     = boundary && irq_accept;
	assign ret_pc   = (finish && (st.op == OP_RETURN))
		? st.stack[st.sp - 3'h1][11:0] : st.pc + 12'h001;
	// a return and a call at one boundary reuse the slot just popped
	assign push_sp  = (finish && (st.op == OP_RETURN))
		? st.sp - 3'h1 : st.sp;
	assign push_pc  = finish ? ret_pc : st.pc;

	always_comb begin
		nx = st;
		nx.wr_seen   = !cs_n && !wr_n;
		nx.ahb.valid = ahb_take;
		nx.ahb.write = hwrite;
		nx.ahb.addr  = haddr[7:0];
		if (ahb_take && !hwrite) begin
			nx.hrdata = reg_read(haddr[7:0], st);
		end

		if (cnt_inc) begin
			nx.count = st.count + 8'h01;
		end
		if (cnt_ovf) begin
			nx.tovf = 1'b1;
			if (st.tmr_en) begin
				// a fresh overflow replaces any held request
				nx.tmr_pend = 1'b1;
			end
		end

		if (dph_wr) begin
			case (st.ahb.addr)
				ADDR_CMD: begin
					if (!st.cmd_pend) begin
						nx.cmd_op   = sit_op_e'(hwdata[3:0]);
						nx.cmd_pend = 1'b1;
					end
				end
				ADDR_ACC: nx.acc = hwdata[7:0];
				ADDR_FLAGS: begin
					nx.bank = hwdata[FLG_BANK];
					nx.f0   = hwdata[FLG_F0];
					nx.f1   = hwdata[FLG_F1];
				end
				default: nx.acc = nx.acc;
			endcase
		end

		if (mcyc_end && (st.fsm == FSM_CYC1) && op_two_cycle(st.op)) begin
			nx.fsm = FSM_CYC2;
			if (st.op == OP_RETURN) begin
				nx.in_service = 1'b0;
			end
		end

		if (finish) begin
			nx.fsm = FSM_IDLE;
			nx.pc  = ret_pc;
			case (st.op)
				OP_EN_EXT: nx.ext_en = 1'b1;
				OP_DIS_EXT: nx.ext_en = 1'b0;
				OP_EN_TMR: nx.tmr_en = 1'b1;
				OP_DIS_TMR: nx.tmr_en = 1'b0;
				OP_START_COUNT: nx.mode = MODE_EVENT;
				OP_START_TIMER: nx.mode = MODE_TIMER;
				OP_STOP: nx.mode = MODE_STOP;
				OP_LOAD_COUNTER: nx.count = st.acc;
				OP_READ_COUNTER: nx.acc = st.count;
				OP_JUMP_TF: begin
					nx.jtf_taken = st.tovf;
					nx.tovf = cnt_ovf;
				end
				OP_IN_DBB: begin
					nx.acc = st.dbb;
					nx.input_buffer_full_flag = 1'b0;
				end
				OP_OUT_PORTS: nx.ports_input = 1'b0;
				OP_RETURN: begin
					nx.sp   = st.sp - 3'h1;
					nx.bank = st.stack[st.sp - 3'h1][12];
					nx.f0   = st.stack[st.sp - 3'h1][13];
				end
				default: nx.fsm = FSM_IDLE;
			endcase
		end

		if (boundary) begin
			if (irq_accept) begin
				// cy and ac live in the arithmetic unit, saved as zero
				nx.stack[push_sp] = {2'b00, nx.f0, nx.bank, push_pc};
				nx.sp = push_sp + 3'h1;
				nx.in_service = 1'b1;
				if (ext_irq) begin
					nx.pc = EXT_VECTOR;
					nx.ext_pend = 1'b0;
				end else begin
					nx.pc = TMR_VECTOR;
					// an overflow in the call's own cycle is a new request
					nx.tmr_pend = cnt_ovf && st.tmr_en;
				end
			end else if (st.cmd_pend && single_step_n) begin
				nx.fsm      = FSM_CYC1;
				nx.op       = st.cmd_op;
				nx.cmd_pend = 1'b0;
			end
		end

		// a master write in the same cycle as a clear still lands
		if (mw_event) begin
			nx.ext_pend = 1'b1;
			nx.input_buffer_full_flag = 1'b1;
			nx.dbb = din;
			nx.f1  = a0;
		end
	end

	// count and stack are data, left as they were through reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st.ahb        <= '0;
			st.hrdata     <= 32'h0000_0000;
			st.fsm        <= FSM_IDLE;
			st.op         <= OP_NOP;
			st.cmd_op     <= OP_NOP;
			st.cmd_pend   <= 1'b0;
			st.acc        <= RST_BYTE;
			st.mode       <= MODE_STOP;
			st.tovf       <= 1'b0;
			st.input_buffer_full_flag        <= 1'b0;
			st.dbb        <= RST_BYTE;
			st.ext_pend   <= 1'b0;
			st.tmr_pend   <= 1'b0;
			st.in_service <= 1'b0;
			st.ext_en     <= 1'b0;
			st.tmr_en     <= 1'b0;
			st.pc         <= RST_PC;
			st.sp         <= RST_SP;
			st.bank       <= 1'b0;
			st.f0         <= 1'b0;
			st.f1         <= 1'b0;
			st.jtf_taken  <= 1'b0;
			st.ports_input <= 1'b1;
			st.wr_seen    <= 1'b0;
		end else begin
			st <= nx;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_master_write;
		mw_event;
	endsequence
	sequence s_ext_entry;
		(st.pc == EXT_VECTOR) && st.in_service && !st.ext_pend;
	endsequence

	ibf_set_a: assert property (s_master_write |=> st.input_buffer_full_flag && st.ext_pend)
		else $error("master write did not raise request and buffer flag");
	ext_call_a: assert property (call && ext_irq |=> s_ext_entry)
		else $error("external interrupt not vectored to address 3");
	tmr_call_a: assert property (call && !ext_irq |=>
		(st.pc == TMR_VECTOR) && st.in_service)
		else $error("timer interrupt not vectored to address 7");
	push_a: assert property (call |=> (st.sp == $past(push_sp) + 3'h1)
		&& (st.stack[$past(push_sp)][11:0] == $past(push_pc)))
		else $error("interrupt did not push the return address");
	one_level_a: assert property (st.in_service && !(mcyc_end
		&& (st.fsm == FSM_CYC1) && (st.op == OP_RETURN)) |=> st.in_service)
		else $error("interrupt level left without a return");
	wrap_a: assert property (cnt_ovf && !finish |=>
		(st.count == 8'h00) && st.tovf)
		else $error("counter overflow did not wrap and flag");
	tmr_nohold_a: assert property (cnt_ovf && !st.tmr_en && !st.tmr_pend
		|=> !st.tmr_pend && st.tovf)
		else $error("disabled timer overflow held a request");
	ext_keep_a: assert property (st.ext_pend && !st.ext_en |=> st.ext_pend)
		else $error("disabled external request was dropped");
	event_inc_a: assert property ((st.mode == MODE_EVENT) && ev_fall
		&& !finish |=> st.count == $past(st.count) + 8'h01)
		else $error("event edge not counted");
	timer_hold_a: assert property ((st.mode == MODE_TIMER) && !tmr_tick
		&& !finish |=> $stable(st.count))
		else $error("timer counted without a prescaled tick");
	jtf_clear_a: assert property (finish && (st.op == OP_JUMP_TF)
		&& !cnt_ovf |=> !st.tovf && (st.jtf_taken == $past(st.tovf)))
		else $error("flag jump did not clear the overflow flag");
	step_hold_a: assert property (mcyc_end && (st.fsm == FSM_IDLE)
		&& !single_step_n |=> st.fsm == FSM_IDLE)
		else $error("instruction started with step input low");

	sequence s_return_second;
		mcyc_end && (st.fsm == FSM_CYC1) && (st.op == OP_RETURN);
	endsequence
	sequence s_level_open;
		!st.in_service && (st.fsm == FSM_CYC2);
	endsequence

	ret_open_a: assert property (s_return_second |=> s_level_open)
		else $error("return did not reopen the interrupt level");
	ibf_clear_a: assert property (finish && (st.op == OP_IN_DBB)
		&& !mw_event |=> !st.input_buffer_full_flag && (st.acc == $past(st.dbb)))
		else $error("buffer input did not clear the buffer flag");
	load_count_a: assert property (finish && (st.op == OP_LOAD_COUNTER)
		|=> st.count == $past(st.acc))
		else $error("counter load did not take the accumulator");
	read_count_a: assert property (finish && (st.op == OP_READ_COUNTER)
		|=> st.acc == $past(st.count))
		else $error("counter read did not reach the accumulator");
	stop_hold_a: assert property ((st.mode == MODE_STOP) && !finish
		|=> $stable(st.count))
		else $error("stopped counter changed its count");
	tmr_keep_a: assert property (st.tmr_pend && !call |=> st.tmr_pend)
		else $error("held timer request was lost");
	tmr_enable_a: assert property (finish && (st.op == OP_EN_TMR)
		|=> st.tmr_en && (st.tmr_pend == $past(st.tmr_pend)))
		else $error("timer enable command misbehaved");
endmodule

//--- testbench/sit_master_model.sv
// far-side model: the master CPU strobing the slave's input buffer,
// plus the external event source on the counter input pin.
// assumes the bench calls its tasks from one process, never overlapping
`timescale 1ns/10ps
module sit_master_model (
	input  wire logic       hclk,            // bus clock
	output logic            cs_n,            // chip select, active low
	output logic            wr_n,            // write strobe, active low
	output logic            a0,              // data/command select
	output logic [7:0]      din,             // data bus
	output logic            event_input_pin  // event source
);
	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		a0 = 1'b0;
		din = 8'h00;
		event_input_pin = 1'b1;
	end

	task automatic put(input logic cmd, input logic [7:0] d);
		@(posedge hclk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		a0 <= cmd;
		din <= d;
		repeat (3) @(posedge hclk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		// a released bus must not keep showing the written byte
		a0 <= ~cmd;
		din <= ~d;
	endtask

	// 400 clocks low then 400 high: one fall per 800 clocks, above
	// three machine cycles, and a long high phase between falls
	task automatic pulse_event();
		@(posedge hclk);
		event_input_pin <= 1'b0;
		repeat (400) @(posedge hclk);
		event_input_pin <= 1'b1;
		repeat (400) @(posedge hclk);
	endtask
endmodule

//--- testbench/test_sit_top.sv
// self-checking bench of the interrupt timer: AHB-Lite master tasks,
// a master/event partner model, and reads checked through a queue.
// assumes hready is looped back from hreadyout, one master only
`timescale 1ns/10ps
module test_sit_top import sit_pkg::*;;
	typedef struct packed {logic [31:0] v; logic [31:0] m;} sit_exp_s;

	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat, acc_v;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        single_step_n = 1'b1, dph_rd = 1'b0;
	logic        hreadyout, hresp, sync_out, port_input_mode;
	logic        cs_n, wr_n, a0, event_input_pin;
	logic [7:0]  din, byte_d;
	int          num_errors = 0, compares = 0, seed = 39660;
	longint      t0;
	sit_exp_s    exp_q[$];
	sit_exp_s    head;

	sit_top sit_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .cs_n(cs_n), .wr_n(wr_n),
		.a0(a0), .din(din), .event_input_pin(event_input_pin),
		.single_step_n(single_step_n), .sync_out(sync_out),
		.port_input_mode(port_input_mode));

	sit_master_model sit_master_model_i (.hclk(hclk), .cs_n(cs_n),
		.wr_n(wr_n), .a0(a0), .din(din),
		.event_input_pin(event_input_pin));

	always #5 hclk = ~hclk;

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// each checked read's data phase pops the oldest note
	always @(posedge hclk) begin
		if (dph_rd && hreadyout === 1'b1 && exp_q.size() > 0) begin
			head = exp_q.pop_front();
			cmp(hrdata & head.m, head.v & head.m);
		end
	end

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic chk);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		dph_rd <= chk;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdat = hrdata;
		dph_rd <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] v,
		input logic [31:0] m);
		exp_q.push_back({v, m});
		ahb(1'b0, a, 32'h0, 1'b1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d, 1'b0);
	endtask

	// polls a register bit, bounded so a stuck bit fails instead of hanging
	task automatic wait_bit(input logic [7:0] a, input int b,
		input logic val, input int n);
		int i;
		i = 0;
		do begin
			ahb(1'b0, a, 32'h0, 1'b0);
			i++;
		end while (rdat[b] !== val && i < n);
		cmp({31'h0, rdat[b]}, {31'h0, val});
	endtask

	// a command written while one is queued would be dropped
	task automatic cmd(input sit_op_e op);
		wait_bit(ADDR_STAT, ST_BUSY, 1'b0, 400);
		wr(ADDR_CMD, {28'h000_0000, op});
	endtask

	task automatic check_reset();
		rd(ADDR_STAT, 32'h0000_0C00, 32'h0000_3C62);
		rd(ADDR_CORE, 32'h0000_0000, 32'h0000_7FFF);
		rd(ADDR_FLAGS, 32'h0000_0000, 32'h0000_0070);
		cmp({31'h0, port_input_mode}, 32'h0000_0001);
		cmp({31'h0, hresp}, 32'h0000_0000);
	endtask

	task automatic test_done();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#600000;
		num_errors++;
		test_done();
	end

	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge sync_out);
		t0 = $time;
		@(posedge sync_out);
		cmp(32'($time - t0), 32'h0000_09C4);
		check_reset();
		rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
		acc_v = $random(seed);
		byte_d = 8'($random(seed));
		wr(ADDR_ACC, acc_v);
		rd(ADDR_ACC, {24'h00_0000, acc_v[7:0]}, 32'hFFFF_FFFF);
		sit_master_model_i.put(1'b1, byte_d);
		rd(ADDR_STAT, 32'h0000_0005, 32'h0000_0025);
		rd(ADDR_FLAGS, 32'h0000_0040, 32'h0000_0040);
		rd(ADDR_DBB, {24'h00_0000, byte_d}, 32'h0000_00FF);
		repeat (600) @(posedge hclk);
		rd(ADDR_STAT, 32'h0000_0004, 32'h0000_0014);
		cmd(OP_EN_EXT);
		wait_bit(ADDR_STAT, ST_INSV, 1'b1, 500);
		rd(ADDR_CORE, 32'h0000_1003, 32'h0000_7FFF);
		cmd(OP_IN_DBB);
		wait_bit(ADDR_STAT, ST_IBF, 1'b0, 500);
		rd(ADDR_ACC, {24'h00_0000, byte_d}, 32'h0000_00FF);
		// overflow while the external routine runs must be held
		wr(ADDR_ACC, 32'h0000_00FF);
		cmd(OP_LOAD_COUNTER);
		cmd(OP_EN_TMR);
		cmd(OP_START_TIMER);
		wait_bit(ADDR_STAT, ST_TOVF, 1'b1, 4000);
		rd(ADDR_COUNT, 32'h0000_0000, 32'h0000_00FF);
		rd(ADDR_STAT, 32'h0000_0018, 32'h0000_0018);
		cmd(OP_RETURN);
		wait_bit(ADDR_STAT, ST_TMRP, 1'b0, 500);
		rd(ADDR_CORE, 32'h0000_1007, 32'h0000_7FFF);
		cmd(OP_JUMP_TF);
		wait_bit(ADDR_STAT, ST_TOVF, 1'b0, 500);
		rd(ADDR_STAT, 32'h0000_0200, 32'h0000_0200);
		cmd(OP_DIS_TMR);
		cmd(OP_START_COUNT);
		wr(ADDR_ACC, 32'h0000_00FE);
		cmd(OP_LOAD_COUNTER);
		wait_bit(ADDR_COUNT, 7, 1'b1, 500);
		sit_master_model_i.pulse_event();
		rd(ADDR_COUNT, 32'h0000_00FF, 32'h0000_00FF);
		cmd(OP_READ_COUNTER);
		wait_bit(ADDR_ACC, 0, 1'b1, 500);
		rd(ADDR_ACC, 32'h0000_00FF, 32'h0000_00FF);
		sit_master_model_i.pulse_event();
		rd(ADDR_COUNT, 32'h0000_0000, 32'h0000_00FF);
		rd(ADDR_STAT, 32'h0000_0002, 32'h0000_000A);
		sit_master_model_i.pulse_event();
		cmd(OP_OUT_PORTS);
		wait_bit(ADDR_STAT, ST_PIN, 1'b0, 500);
		cmp({31'h0, port_input_mode}, 32'h0000_0000);
		// reset in mid-run: count and stack kept, everything else back to rest
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		check_reset();
		rd(ADDR_COUNT, 32'h0000_0001, 32'h0000_00FF);
		sit_master_model_i.pulse_event();
		rd(ADDR_COUNT, 32'h0000_0001, 32'h0000_00FF);
		cmd(OP_START_COUNT);
		wait_bit(ADDR_STAT, ST_MODE + 2, 1'b1, 500);
		sit_master_model_i.pulse_event();
		cmd(OP_STOP);
		wait_bit(ADDR_STAT, ST_MODE, 1'b1, 500);
		sit_master_model_i.pulse_event();
		rd(ADDR_COUNT, 32'h0000_0002, 32'h0000_00FF);
		@(posedge hclk);
		single_step_n <= 1'b0;
		cmd(OP_NOP);
		repeat (750) @(posedge hclk);
		rd(ADDR_STAT, 32'h0000_0180, 32'h0000_0180);
		@(posedge hclk);
		single_step_n <= 1'b1;
		wait_bit(ADDR_STAT, ST_BUSY, 1'b0, 500);
		// step logic drops the input again once sync falls
		@(negedge sync_out);
		@(posedge hclk);
		single_step_n <= 1'b0;
		cmd(OP_NOP);
		repeat (750) @(posedge hclk);
		rd(ADDR_STAT, 32'h0000_0180, 32'h0000_0180);
		test_done();
	end
endmodule
